/* File: design/cfk_fader.sv */
// colour-key fader merging compressed-video and video-port pixel streams
`timescale 1ns/100ps
`include "cfk_params.svh"
module cfk_fader #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   // byte register port, one subaddress per access
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic             reg_wr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_rd_i,
   output logic [7:0]            reg_rdata_o,
   output logic                  reg_rvalid_o,
   // compressed-video pixel stream
   input  wire logic             cmp_valid_i,
   output logic                  cmp_ready_o,
   input  wire cfk_pkg::cfk_pix_s cmp_pix_i,
   // video-port pixel stream
   input  wire logic             vid_valid_i,
   output logic                  vid_ready_o,
   input  wire cfk_pkg::cfk_pix_s vid_pix_i,
   // merged stream towards the encoder and rgb paths
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output cfk_pkg::cfk_pix_s     enc_pix_o,
   output cfk_pkg::cfk_pix_s     rgb_pix_o,
   output cfk_pkg::cfk_mode_e    mode_o
);
   import cfk_pkg::*;

   localparam int OUT_W = $bits(cfk_out_s);

   // refused at elaboration: the buffer needs at least two words
   if (FIFO_DEPTH < 2)
   begin : g_depth_check
      $error("cfk_fader: FIFO_DEPTH must be at least 2");
   end

   // control registers
   cfk_pix_s   key_a_low;
   cfk_pix_s   key_a_high;
   cfk_pix_s   key_b_low;
   cfk_pix_s   key_b_high;
   cfk_pix_s   lookup;
   cfk_ratio_t key_a_blend_ratio;
   cfk_ratio_t key_b_blend_ratio;
   cfk_ratio_t default_blend_ratio;
   logic       video_override;
   logic       compressed_override;
   logic       encoder_path_select;
   logic       rgb_path_select;
   logic       compressed_input_format;
   logic       video_input_format;

   // pipeline and buffer signals
   logic       take;
   logic       stage_ready;
   logic       stg_valid;
   cfk_out_s   stg_word;
   cfk_mode_e  stg_mode;
   cfk_pix_s   cmp_bin;
   cfk_pix_s   vid_bin;
   logic       hit_a;
   logic       hit_b;
   cfk_mode_e  next_mode;
   cfk_pix_s   next_faded;
   cfk_out_s   next_word;
   logic       fifo_in_ready;
   logic [OUT_W+4:0] fifo_out; // mode tag rides above the pixel pair
   cfk_out_s   out_word;
   logic [7:0] next_rdata;

   // twos complement to straight binary is an msb flip
   function automatic cfk_pix_s to_binary(input cfk_pix_s p, input logic straight);
      cfk_pix_s r;
      r = p;
      if (!straight)
      begin
         r.u[7] = ~p.u[7];
         r.v[7] = ~p.v[7];
         r.y[7] = ~p.y[7];
      end
      return r;
   endfunction

   // inclusive window test on all three components
   function automatic logic in_window(input cfk_pix_s p, input cfk_pix_s lo,
                                      input cfk_pix_s hi);
      return (p.u >= lo.u) && (p.u <= hi.u) && (p.v >= lo.v) && (p.v <= hi.v) &&
             (p.y >= lo.y) && (p.y <= hi.y);
   endfunction

   // (k*a + (63-k)*b)/63 rounded; 3fh gives a exactly, 00h gives b exactly
   function automatic logic [7:0] blend8(input cfk_ratio_t k, input logic [7:0] a,
                                         input logic [7:0] b);
      logic [14:0] acc;
      logic [14:0] quo;
      acc = 15'(k) * 15'(a) + 15'(`CFK_RATIO_FULL - k) * 15'(b) + 15'd31;
      quo = acc / 15'd63;
      return quo[7:0];
   endfunction

   function automatic cfk_pix_s blend_pix(input cfk_ratio_t k, input cfk_pix_s a,
                                          input cfk_pix_s b);
      cfk_pix_s r;
      r.u = blend8(k, a.u, b.u);
      r.v = blend8(k, a.v, b.v);
      r.y = blend8(k, a.y, b.y);
      return r;
   endfunction

   // key window limits; each byte has its own subaddress
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         key_a_low  <= '{`CFK_RST_KEY, `CFK_RST_KEY, `CFK_RST_KEY};
         key_a_high <= '{`CFK_RST_KEY, `CFK_RST_KEY, `CFK_RST_KEY};
         key_b_low  <= '{`CFK_RST_KEY, `CFK_RST_KEY, `CFK_RST_KEY};
         key_b_high <= '{`CFK_RST_KEY, `CFK_RST_KEY, `CFK_RST_KEY};
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `CFK_OFS_KEY_A_LOW_U)
            key_a_low.u <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_A_LOW_V)
            key_a_low.v <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_A_LOW_Y)
            key_a_low.y <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_U)
            key_b_low.u <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_V)
            key_b_low.v <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_Y)
            key_b_low.y <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_U)
            key_a_high.u <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_V)
            key_a_high.v <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_Y)
            key_a_high.y <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_U)
            key_b_high.u <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_V)
            key_b_high.v <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_Y)
            key_b_high.y <= reg_wdata_i;
      end
   end

   // blend ratios and override bits; reserved top bits are simply not stored
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         key_a_blend_ratio   <= `CFK_RST_RATIO;
         key_b_blend_ratio   <= `CFK_RST_RATIO;
         default_blend_ratio <= `CFK_RST_RATIO;
         video_override      <= `CFK_RST_OVR;
         compressed_override <= `CFK_RST_OVR;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `CFK_OFS_KEY_A_RATIO)
            key_a_blend_ratio <= reg_wdata_i[5:0];
         else if (reg_addr_i == `CFK_OFS_OVR_KEY_B)
         begin
            video_override      <= reg_wdata_i[`CFK_BIT_VID_OVR];
            compressed_override <= reg_wdata_i[`CFK_BIT_CMP_OVR];
            key_b_blend_ratio   <= reg_wdata_i[5:0];
         end
         else if (reg_addr_i == `CFK_OFS_NO_KEY_RATIO)
            default_blend_ratio <= reg_wdata_i[5:0];
      end
   end

   // lookup colour inserted on key b and in the override modes
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lookup <= '{`CFK_RST_LOOKUP, `CFK_RST_LOOKUP, `CFK_RST_LOOKUP};
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `CFK_OFS_LOOKUP_U)
            lookup.u <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_LOOKUP_V)
            lookup.v <= reg_wdata_i;
         else if (reg_addr_i == `CFK_OFS_LOOKUP_Y)
            lookup.y <= reg_wdata_i;
      end
   end

   // input format and path select bits
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         compressed_input_format <= `CFK_RST_FMT;
         video_input_format      <= `CFK_RST_FMT;
         encoder_path_select     <= `CFK_RST_PATH;
         rgb_path_select         <= `CFK_RST_PATH;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `CFK_OFS_INFMT)
         begin
            compressed_input_format <= reg_wdata_i[`CFK_BIT_CMP_FMT];
            video_input_format      <= reg_wdata_i[`CFK_BIT_VID_FMT];
         end
         else if (reg_addr_i == `CFK_OFS_PATH)
         begin
            encoder_path_select <= reg_wdata_i[`CFK_BIT_ENC_SEL];
            rgb_path_select     <= reg_wdata_i[`CFK_BIT_RGB_SEL];
         end
      end
   end

   // read decode; unmapped subaddresses and unheld bits read zero
   always_comb
   begin
      next_rdata = 8'h00;
      if (reg_addr_i == `CFK_OFS_KEY_A_LOW_U)
         next_rdata = key_a_low.u;
      else if (reg_addr_i == `CFK_OFS_KEY_A_LOW_V)
         next_rdata = key_a_low.v;
      else if (reg_addr_i == `CFK_OFS_KEY_A_LOW_Y)
         next_rdata = key_a_low.y;
      else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_U)
         next_rdata = key_b_low.u;
      else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_V)
         next_rdata = key_b_low.v;
      else if (reg_addr_i == `CFK_OFS_KEY_B_LOW_Y)
         next_rdata = key_b_low.y;
      else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_U)
         next_rdata = key_a_high.u;
      else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_V)
         next_rdata = key_a_high.v;
      else if (reg_addr_i == `CFK_OFS_KEY_A_HIGH_Y)
         next_rdata = key_a_high.y;
      else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_U)
         next_rdata = key_b_high.u;
      else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_V)
         next_rdata = key_b_high.v;
      else if (reg_addr_i == `CFK_OFS_KEY_B_HIGH_Y)
         next_rdata = key_b_high.y;
      else if (reg_addr_i == `CFK_OFS_KEY_A_RATIO)
         next_rdata = {2'h0, key_a_blend_ratio};
      else if (reg_addr_i == `CFK_OFS_OVR_KEY_B)
         next_rdata = {video_override, compressed_override, key_b_blend_ratio};
      else if (reg_addr_i == `CFK_OFS_NO_KEY_RATIO)
         next_rdata = {2'h0, default_blend_ratio};
      else if (reg_addr_i == `CFK_OFS_LOOKUP_U)
         next_rdata = lookup.u;
      else if (reg_addr_i == `CFK_OFS_LOOKUP_V)
         next_rdata = lookup.v;
      else if (reg_addr_i == `CFK_OFS_LOOKUP_Y)
         next_rdata = lookup.y;
      else if (reg_addr_i == `CFK_OFS_INFMT)
         next_rdata = {6'h00, compressed_input_format, video_input_format};
      else if (reg_addr_i == `CFK_OFS_PATH)
         next_rdata = {2'h0, encoder_path_select, rgb_path_select, 4'h0};
   end

   // read answer one cycle after the strobe
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
            reg_rdata_o <= next_rdata;
      end
   end

   // both streams are joined: a pixel is taken only when both offer one
   assign stage_ready = !stg_valid || fifo_in_ready;
   assign take        = cmp_valid_i && vid_valid_i && stage_ready;
   assign cmp_ready_o = stage_ready && vid_valid_i;
   assign vid_ready_o = stage_ready && cmp_valid_i;

   assign cmp_bin = to_binary(cmp_pix_i, compressed_input_format);
   assign vid_bin = to_binary(vid_pix_i, video_input_format);
   assign hit_a   = in_window(cmp_bin, key_a_low, key_a_high);
   assign hit_b   = in_window(cmp_bin, key_b_low, key_b_high);

   // mode choice: overrides mask both keys, video override beats compressed
   always_comb
   begin
      if (video_override)
         next_mode = CFK_VID_OVR;
      else if (compressed_override)
         next_mode = CFK_CMP_OVR;
      else if (hit_a)
         next_mode = CFK_KEY_A;
      else if (hit_b)
         next_mode = CFK_KEY_B;
      else
         next_mode = CFK_DEFAULT;
   end

   // the blend itself; every ratio is read as code/63 with rounding
   always_comb
   begin
      case (next_mode)
         CFK_VID_OVR: next_faded = blend_pix(key_b_blend_ratio, vid_bin, lookup);
         CFK_CMP_OVR: next_faded = blend_pix(key_b_blend_ratio, cmp_bin, lookup);
         CFK_KEY_A:   next_faded = blend_pix(key_a_blend_ratio, vid_bin, cmp_bin);
         CFK_KEY_B:   next_faded = blend_pix(key_b_blend_ratio, vid_bin, lookup);
         default:     next_faded = blend_pix(default_blend_ratio, vid_bin, cmp_bin);
      endcase
   end

   // bypass hands the raw compressed word through untouched
   always_comb
   begin
      next_word.enc = encoder_path_select ? next_faded : cmp_pix_i;
      next_word.rgb = rgb_path_select ? next_faded : cmp_pix_i;
   end

   // one pipeline stage in front of the buffer keeps the divider off the fifo
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stg_valid <= 1'b0;
         stg_word  <= '0;
         stg_mode  <= CFK_DEFAULT;
      end
      else if (stage_ready)
      begin
         stg_valid <= take;
         if (take)
         begin
            stg_word <= next_word;
            stg_mode <= next_mode;
         end
      end
   end

   // output buffer; its fullness stalls the stage and so both sources
   cfk_fifo #(
      .WIDTH (OUT_W + 5),
      .DEPTH (FIFO_DEPTH)
   ) u_buf (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (stg_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({stg_mode, stg_word}),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  (fifo_out)
   );

   assign out_word  = cfk_out_s'(fifo_out[OUT_W-1:0]);
   assign enc_pix_o = out_word.enc;
   assign rgb_pix_o = out_word.rgb;
   assign mode_o    = cfk_mode_e'(fifo_out[OUT_W+4:OUT_W]);
endmodule // cfk_fader

/* File: shared/cfk_params.svh */
// offsets, field positions and reset values of the colour-key fader registers
`ifndef CFK_PARAMS_SVH
`define CFK_PARAMS_SVH

`define CFK_OFS_INFMT        8'h3a
`define CFK_OFS_KEY_A_LOW_U  8'h42
`define CFK_OFS_KEY_A_LOW_V  8'h43
`define CFK_OFS_KEY_A_LOW_Y  8'h44
`define CFK_OFS_KEY_B_LOW_U  8'h45
`define CFK_OFS_KEY_B_LOW_V  8'h46
`define CFK_OFS_KEY_B_LOW_Y  8'h47
`define CFK_OFS_KEY_A_HIGH_U 8'h48
`define CFK_OFS_KEY_A_HIGH_V 8'h49
`define CFK_OFS_KEY_A_HIGH_Y 8'h4a
`define CFK_OFS_KEY_B_HIGH_U 8'h4b
`define CFK_OFS_KEY_B_HIGH_V 8'h4c
`define CFK_OFS_KEY_B_HIGH_Y 8'h4d
`define CFK_OFS_KEY_A_RATIO  8'h4e
`define CFK_OFS_OVR_KEY_B    8'h4f
`define CFK_OFS_NO_KEY_RATIO 8'h50
`define CFK_OFS_LOOKUP_U     8'h51
`define CFK_OFS_LOOKUP_V     8'h52
`define CFK_OFS_LOOKUP_Y     8'h53
`define CFK_OFS_PATH         8'h54

`define CFK_BIT_CMP_FMT      1
`define CFK_BIT_VID_FMT      0
`define CFK_BIT_VID_OVR      7
`define CFK_BIT_CMP_OVR      6
`define CFK_BIT_ENC_SEL      5
`define CFK_BIT_RGB_SEL      4

`define CFK_RST_KEY          8'h80
`define CFK_RST_LOOKUP       8'h80
`define CFK_RST_RATIO        6'h3f
`define CFK_RST_OVR          1'h0
`define CFK_RST_PATH         1'h0
`define CFK_RST_FMT          1'h1
`define CFK_RATIO_FULL       6'h3f

`endif

/* File: shared/cfk_pkg.sv */
// types shared by the colour-key fader, its checker and the bench models
package cfk_pkg;

   typedef logic [5:0] cfk_ratio_t;

   // one 4:2:2 sample point carried as its three components
   typedef struct packed {
      logic [7:0] u;
      logic [7:0] v;
      logic [7:0] y;
   } cfk_pix_s;

   // one buffered word: what the encoder path and the rgb path each take
   typedef struct packed {
      cfk_pix_s enc;
      cfk_pix_s rgb;
   } cfk_out_s;

   // which blend the fader applied to a pixel
   typedef enum logic [4:0] {
      CFK_DEFAULT = 5'b00001,
      CFK_KEY_A   = 5'b00010,
      CFK_KEY_B   = 5'b00100,
      CFK_VID_OVR = 5'b01000,
      CFK_CMP_OVR = 5'b10000
   } cfk_mode_e;

endpackage

/* File: design/cfk_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module cfk_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // pointer wrap relies on a power-of-two depth; refused at elaboration
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_size_check
      $error("cfk_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   // honest full and empty straight from the occupancy count
   assign in_ready_o  = (count != CW'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ptr];

   // storage has no reset; only occupied words are ever presented
   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   // pointers and count
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         if (push && !pop)
            count <= count + CW'(1);
         else if (pop && !push)
            count <= count - CW'(1);
      end
   end
endmodule // cfk_fifo

/* File: sim/cfk_checker.sv */
// port-level assertions for the colour-key fader
`timescale 1ns/100ps
module cfk_checker (
   input wire logic               mclk_i,
   input wire logic               rst_n_i,
   input wire logic [7:0]         reg_addr_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire logic               reg_rvalid_o,
   input wire logic               cmp_valid_i,
   input wire logic               cmp_ready_o,
   input wire logic               vid_valid_i,
   input wire logic               vid_ready_o,
   input wire logic               out_valid_o,
   input wire logic               out_ready_i,
   input wire cfk_pkg::cfk_pix_s  enc_pix_o,
   input wire cfk_pkg::cfk_pix_s  rgb_pix_o,
   input wire cfk_pkg::cfk_mode_e mode_o
);
   import cfk_pkg::*;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // register port: one answer per strobe, data held between reads
   property p_rvalid;
      reg_rvalid_o == $past(reg_rd_i);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer off");
   property p_rdata_hold;
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   // key A and default ratio bytes keep their two top bits clear
   property p_rsvd_a;
      reg_rd_i && reg_addr_i == 8'h4e |=> reg_rdata_o[7:6] == 2'b00;
   endproperty
   a_rsvd_a: assert property (p_rsvd_a) else $error("key ratio top bits");
   property p_rsvd_d;
      reg_rd_i && reg_addr_i == 8'h50 |=> reg_rdata_o[7:6] == 2'b00;
   endproperty
   a_rsvd_d: assert property (p_rsvd_d) else $error("default ratio top bits");
   // the two streams are only ever taken as a pair: offered together, readys agree
   property p_pair;
      cmp_valid_i && vid_valid_i |-> cmp_ready_o == vid_ready_o;
   endproperty
   a_pair: assert property (p_pair) else $error("unpaired take");
   property p_first;
      cmp_valid_i && cmp_ready_o && !out_valid_o |-> ##2 out_valid_o;
   endproperty
   a_first: assert property (p_first) else $error("pixel latency");
   // a stalled output word must not change under the sink
   property p_hold;
      out_valid_o && !out_ready_i |=>
         out_valid_o && $stable({enc_pix_o, rgb_pix_o, mode_o});
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
   property p_mode;
      out_valid_o |-> $onehot(mode_o);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not one-hot");
   c_take: cover property (cmp_valid_i && cmp_ready_o);
   c_stall: cover property (out_valid_o && !out_ready_i ##1 out_valid_o);
   c_key_b: cover property (out_valid_o && mode_o == CFK_KEY_B);
endmodule // cfk_checker

/* File: sim/cfk_source.sv */
// upstream model: paired compressed and video pixel sources
`timescale 1ns/100ps
module cfk_source (
   input  wire logic         mclk_i,
   input  wire logic         cmp_ready_i,
   input  wire logic         vid_ready_i,
   output logic              cmp_valid_o,
   output logic              vid_valid_o,
   output cfk_pkg::cfk_pix_s cmp_pix_o,
   output cfk_pkg::cfk_pix_s vid_pix_o
);
   import cfk_pkg::*;
   logic taken;
   // both sources idle until the first offer
   initial {cmp_valid_o, vid_valid_o, taken, cmp_pix_o, vid_pix_o} = '0;
   // offer one pair, video lag cycles late; give up after lim cycles
   task automatic send(input cfk_pix_s c, input cfk_pix_s v, input int lag, input int lim);
      int n;
      @(posedge mclk_i) #1 taken = 1'b0;
      cmp_pix_o = c;
      cmp_valid_o = 1'b1;
      repeat (lag) @(posedge mclk_i);
      if (lag > 0) #1;
      vid_pix_o = v;
      vid_valid_o = 1'b1;
      // ready is settled at the falling edge, so the next rising edge takes
      for (n = 0; n < lim && !taken; n++)
      begin
         @(negedge mclk_i) taken = cmp_ready_i && vid_ready_i;
         @(posedge mclk_i);
      end
      #1 cmp_valid_o = 1'b0;
      vid_valid_o = 1'b0;
      // released lines show the inverse so stale data cannot pass as fresh
      cmp_pix_o = ~c;
      vid_pix_o = ~v;
   endtask
endmodule // cfk_source

/* File: sim/testbench.sv */
// self-checking bench for the colour-key fader
`timescale 1ns/100ps
module testbench;
   import cfk_pkg::*;
   localparam int       DEPTH = 16;
   localparam cfk_pix_s VID   = 24'haabbcc;
   localparam cfk_pix_s LUT   = 24'h506070;
   typedef struct {
      logic [7:0] ovr;
      logic [5:0] ka;
      logic [5:0] kd;
      cfk_pix_s   c;
      cfk_mode_e  m;
   } cfk_row_s;
   logic       mclk_i = 1'b0;
   logic       rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, out_valid_o, out_ready_i;
   logic       cmp_valid_i, cmp_ready_o, vid_valid_i, vid_ready_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d, x;
   cfk_pix_s   cmp_pix_i, vid_pix_i, enc_pix_o, rgb_pix_o, enc, rgb, e;
   cfk_mode_e  mode_o, mode;
   int         errors = 0;
   int         comparisons = 0;
   int         i;
   cfk_row_s   rows [10];
   always #20 mclk_i = ~mclk_i;
   cfk_fader #(.FIFO_DEPTH(DEPTH)) cfk_fader_i (.*);
   cfk_source cfk_source_i (
      .mclk_i      (mclk_i),
      .cmp_ready_i (cmp_ready_o),
      .vid_ready_i (vid_ready_o),
      .cmp_valid_o (cmp_valid_i),
      .vid_valid_o (vid_valid_i),
      .cmp_pix_o   (cmp_pix_i),
      .vid_pix_o   (vid_pix_i)
   );
   // compare and count; four-state so an unknown never matches
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      errors += int'(seen !== exp);
      if (seen !== exp)
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
   endtask
   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // byte register access, one idle edge before each strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_i) #1 reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      @(posedge mclk_i) #1 reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i) #1 reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge mclk_i) #1 reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask
   // wait for a word, take it and pop it; the sink stalls a cycle each time
   task automatic get;
      int n;
      n = 0;
      do
         @(posedge mclk_i) #1 n++;
      while (out_valid_o !== 1'b1 && n < 60);
      chk(out_valid_o, 1'b1);
      if (out_valid_o !== 1'b1)
         print_verdict;
      {enc, rgb} = {enc_pix_o, rgb_pix_o};
      mode = mode_o;
      out_ready_i = 1'b1;
      @(posedge mclk_i) #1 out_ready_i = 1'b0;
   endtask
   // ratio k out of 63 of a, the rest of b, rounded
   function automatic cfk_pix_s mix(input int k, input cfk_pix_s a, input cfk_pix_s b);
      cfk_pix_s r;
      r.u = 8'((k * a.u + (63 - k) * b.u + 31) / 63);
      r.v = 8'((k * a.v + (63 - k) * b.v + 31) / 63);
      r.y = 8'((k * a.y + (63 - k) * b.y + 31) / 63);
      return r;
   endfunction
   initial
   begin
      {rst_n_i, reg_wr_i, reg_rd_i, out_ready_i, reg_addr_i, reg_wdata_i} = '0;
      rows = '{
         '{8'h3f, 6'h3f, 6'h00, 24'h101010, CFK_KEY_A},
         '{8'h3f, 6'h00, 6'h3f, 24'h202020, CFK_KEY_A},
         '{8'h3f, 6'h15, 6'h3f, 24'h181920, CFK_KEY_A},
         '{8'h20, 6'h3f, 6'h3f, 24'h303540, CFK_KEY_B},
         '{8'h00, 6'h3f, 6'h3f, 24'h212121, CFK_KEY_B},
         '{8'h3f, 6'h3f, 6'h20, 24'h211010, CFK_DEFAULT},
         '{8'h3f, 6'h3f, 6'h00, 24'h414141, CFK_DEFAULT},
         '{8'h8a, 6'h3f, 6'h3f, 24'h101010, CFK_VID_OVR},
         '{8'h45, 6'h3f, 6'h3f, 24'h303030, CFK_CMP_OVR},
         '{8'hc5, 6'h3f, 6'h3f, 24'h303030, CFK_VID_OVR}};
      repeat (5) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      // reset map; 41h is unmapped and reads zero
      for (i = 8'h41; i <= 8'h54; i++)
      begin
         rd(i[7:0]);
         x = (i == 8'h41 || i == 8'h54) ? 8'h00 : (i >= 8'h4e && i <= 8'h50) ? 8'h3f : 8'h80;
         chk(d, x); // reset value
      end
      rd(8'h3a);
      chk(d, 8'h03);
      // paths start bypassed: both carry the raw compressed pixel
      cfk_source_i.send(24'h123456, VID, 1, 40);
      get;
      chk(enc, 24'h123456);
      chk(rgb, 24'h123456);
      wr(8'h4e, 8'h2a); // top bits kept clear
      rd(8'h4e);
      chk(d, 8'h2a);
      // key A 10h..20h and key B 18h..40h overlap on purpose
      for (i = 0; i < 3; i++)
      begin
         wr(8'h42 + i[7:0], 8'h10);
         wr(8'h48 + i[7:0], 8'h20);
         wr(8'h45 + i[7:0], 8'h18);
         wr(8'h4b + i[7:0], 8'h40);
         wr(8'h51 + i[7:0], LUT[23 - 8 * i -: 8]);
      end
      wr(8'h54, 8'h30);
      foreach (rows[r])
      begin
         wr(8'h4f, rows[r].ovr);
         wr(8'h4e, {2'b00, rows[r].ka}); // top bits kept clear
         wr(8'h50, {2'b00, rows[r].kd}); // top bits kept clear
         cfk_source_i.send(rows[r].c, VID, r % 3, 40);
         get;
         case (rows[r].m)
            CFK_KEY_A: e = mix(rows[r].ka, VID, rows[r].c);
            CFK_CMP_OVR: e = mix(rows[r].ovr[5:0], rows[r].c, LUT);
            CFK_DEFAULT: e = mix(rows[r].kd, VID, rows[r].c);
            default: e = mix(rows[r].ovr[5:0], VID, LUT);
         endcase
         chk(mode, rows[r].m);
         chk(enc, e);
         chk(rgb, e);
      end
      // twos complement input: 90h reads as 10h, inside key A
      wr(8'h4f, 8'h3f);
      wr(8'h3a, 8'h00);
      cfk_source_i.send(24'h909090, VID, 0, 40);
      get;
      chk(mode, CFK_KEY_A);
      chk(enc, VID ^ 24'h808080); // all video, msb flipped
      wr(8'h3a, 8'h03);
      // fill with the sink stalled until refused, then drain in order
      for (i = 0; i <= DEPTH; i++)
      begin
         cfk_source_i.send(24'h000000, {16'h0000, i[7:0]}, 0, 40);
         chk(cfk_source_i.taken, 1'b1);
      end
      cfk_source_i.send(24'h000000, VID, 0, 4);
      chk(cfk_source_i.taken, 1'b0);
      for (i = 0; i <= DEPTH; i++)
      begin
         get;
         chk(enc, {16'h0000, i[7:0]});
      end
      chk(out_valid_o, 1'b0);
      print_verdict;
   end
endmodule // testbench
bind cfk_fader cfk_checker cfk_checker_i (.*);
